// [design/bfp_fifo.sv]
// One 18-bit FIFO array with its four fill-level flags
`timescale 1ns/1ps
`default_nettype none
module bfp_fifo #(
    parameter bit MARK_ON_READ = 1'b1
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic clr,
    input wire logic push,
    input wire logic [17:0] wdata,
    input wire logic pop,
    output logic [17:0] rdata,
    input wire logic mark_load,
    input wire logic mark_restore,
    input wire logic full_use_mark,
    input wire logic empty_use_mark,
    input wire logic [bfp_pkg::OFFW-1:0] ae_off,
    input wire logic [bfp_pkg::OFFW-1:0] af_off,
    output logic empty,
    output logic almost_empty,
    output logic almost_full,
    output logic full
);
    logic [17:0] mem_q [bfp_pkg::DEPTH];
    logic [bfp_pkg::PW-1:0] wp_q, wp_d, rp_q, rp_d, mk_q, mk_d, cnt;
    logic empty_q, empty_d, full_q, full_d, ae_q, ae_d, af_q, af_d;

    always_comb begin
        wp_d = wp_q;
        rp_d = rp_q;
        mk_d = mk_q;
        if (clr) begin
            wp_d = '0;
            rp_d = '0;
            mk_d = '0;
        end else begin
            if (push && !full_q)
                wp_d = wp_q + 1'b1;
            if (pop && !empty_q)
                rp_d = rp_q + 1'b1;
            if (mark_load)
                mk_d = MARK_ON_READ ? rp_q : wp_q;
            if (mark_restore && MARK_ON_READ)
                rp_d = mk_q;
            if (mark_restore && !MARK_ON_READ)
                wp_d = mk_q;
        end
        // Full and empty follow the new pointers at once
        full_d = (wp_d - (full_use_mark ? mk_d : rp_d)) == bfp_pkg::DEPTH_P;
        empty_d = rp_d == (empty_use_mark ? mk_d : wp_d);
        // Almost flags come from the settled count, so they change one cycle after full and empty
        cnt = wp_q - rp_q;
        ae_d = cnt <= ae_off;
        af_d = cnt >= (bfp_pkg::DEPTH_P - af_off);
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wp_q <= '0;
            rp_q <= '0;
            mk_q <= '0;
            empty_q <= 1'b1;
            full_q <= 1'b0;
            ae_q <= 1'b1;
            af_q <= 1'b0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            mk_q <= mk_d;
            empty_q <= empty_d;
            full_q <= full_d;
            ae_q <= ae_d;
            af_q <= af_d;
        end
    end

    // Storage has no reset; contents are undefined until written
    always_ff @(posedge mclk) begin
        if (push && !full_q && !clr)
            mem_q[wp_q[bfp_pkg::AW-1:0]] <= wdata;
    end

    assign rdata = mem_q[rp_q[bfp_pkg::AW-1:0]];
    assign empty = empty_q;
    assign full = full_q;
    assign almost_empty = ae_q;
    assign almost_full = af_q;
endmodule // bfp_fifo
`default_nettype wire

// [design/bfp_port_b.sv]
// Narrow-port packing, parity, DMA timing and flag routing
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Bits 8/9 pick parity generate or check
// - Bit 10 picks odd or even parity
// - Bit 11 puts parity error on pin A
// - Each array keeps four fill flags
// - Almost offsets programmable over full depth
// - Reset clears all almost offsets
// - Almost flags update later than empty/full
// - Three-bit code routes flag to pin
// - Format 1 shows eight flags, format 0 four
// - Bit 0 selects strobe style
// - Bit 10 selects processor or peripheral mode
// - Reset gives processor mode, separate strobes
// - First write held, valid bit set
// - Second write pushes word, clears valid
// - Reads alternate halves, pop every second
// - Bit 1 sets byte order
// - Bit 2 redefines full condition
// - Bit 3 redefines empty condition
// - Bits 7-6 set request-to-acknowledge delay
// - Bit 8 sets strobe length
// - Bit 9 divides internal clock by two
// - Bits 12-11 set width expansion
// - Route register holds four pin codes
// - Bits 4/5 set request/acknowledge polarity
// - Acknowledge withheld on empty or full
// - DMA controls ignored in processor mode
module bfp_port_b (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic reset_all,
    input wire logic cfg_wr,
    input wire logic [2:0] cfg_idx,
    input wire logic [15:0] cfg_wdata,
    input wire logic status_format,
    output logic [15:0] status_word,
    input wire logic fwd_push,
    input wire logic [17:0] fwd_wdata,
    input wire logic rev_pop,
    output logic [17:0] rev_rdata,
    input wire logic ld_reread,
    input wire logic reread,
    input wire logic ld_rewrite,
    input wire logic rewrite,
    input wire logic ext_clk,
    input wire logic dma_req,
    input wire logic dma_dir_read,
    output logic dma_ack,
    input wire logic narrow_port_read_strobe_n_i,
    output logic narrow_port_read_strobe_n_o,
    input wire logic narrow_port_write_strobe_n_i,
    output logic narrow_port_write_strobe_n_o,
    input wire logic narrow_port_data_strobe_n_i,
    output logic narrow_port_data_strobe_n_o,
    input wire logic narrow_port_direction_line_i,
    output logic narrow_port_direction_line_o,
    output logic narrow_port_ctrl_oe_n,
    input wire logic [8:0] narrow_port_data_bits_i,
    output logic [8:0] narrow_port_data_bits_o,
    output logic narrow_port_data_oe_n,
    output logic [3:0] external_flag_pins
);
    // ************************************************
    // Configuration registers
    // ************************************************
    logic [15:0] gc_q, gc_d, pc_q, pc_d, fr_q, fr_d;
    logic [bfp_pkg::OFFW-1:0] off_q [4];
    logic [bfp_pkg::OFFW-1:0] off_d [4];

    always_comb begin
        gc_d = gc_q;
        pc_d = pc_q;
        fr_d = fr_q;
        for (int i = 0; i < 4; i++)
            off_d[i] = off_q[i];
        if (reset_all) begin
            gc_d = bfp_pkg::GC_RST;
            pc_d = bfp_pkg::PC_RST;
            fr_d = bfp_pkg::FR_RST;
            for (int i = 0; i < 4; i++)
                off_d[i] = bfp_pkg::OFF_RST;
        end else if (cfg_wr) begin
            if (cfg_idx == bfp_pkg::CFG_GEN_CTRL)
                gc_d = cfg_wdata;
            else if (cfg_idx == bfp_pkg::CFG_PARITY)
                pc_d = cfg_wdata;
            else if (cfg_idx == bfp_pkg::CFG_FLAG_ROUTE)
                fr_d = cfg_wdata;
            else if (cfg_idx[2] == 1'b0)
                off_d[cfg_idx[1:0]] = cfg_wdata[bfp_pkg::OFFW-1:0];
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            gc_q <= bfp_pkg::GC_RST;
            pc_q <= bfp_pkg::PC_RST;
            fr_q <= bfp_pkg::FR_RST;
            for (int i = 0; i < 4; i++)
                off_q[i] <= bfp_pkg::OFF_RST;
        end else begin
            gc_q <= gc_d;
            pc_q <= pc_d;
            fr_q <= fr_d;
            for (int i = 0; i < 4; i++)
                off_q[i] <= off_d[i];
        end
    end

    // ************************************************
    // Arrays and the eight internal flags
    // ************************************************
    logic [7:0] flags;
    logic [17:0] fwd_rdata, rev_word, rev_rdata_w;
    logic fwd_pop, rev_push;

    bfp_fifo #(.MARK_ON_READ(1'b1)) u_fwd (
        .mclk(mclk), .nrst(nrst), .clr(reset_all), .push(fwd_push), .wdata(fwd_wdata),
        .pop(fwd_pop), .rdata(fwd_rdata), .mark_load(ld_reread), .mark_restore(reread),
        .full_use_mark(gc_q[bfp_pkg::GC_FULL_DEF]), .empty_use_mark(1'b0),
        .ae_off(off_q[0]), .af_off(off_q[1]), .empty(flags[0]), .almost_empty(flags[1]),
        .almost_full(flags[3]), .full(flags[2])
    );
    bfp_fifo #(.MARK_ON_READ(1'b0)) u_rev (
        .mclk(mclk), .nrst(nrst), .clr(reset_all), .push(rev_push), .wdata(rev_word),
        .pop(rev_pop), .rdata(rev_rdata_w), .mark_load(ld_rewrite), .mark_restore(rewrite),
        .full_use_mark(1'b0), .empty_use_mark(gc_q[bfp_pkg::GC_EMPTY_DEF]),
        .ae_off(off_q[2]), .af_off(off_q[3]), .empty(flags[4]), .almost_empty(flags[5]),
        .almost_full(flags[7]), .full(flags[6])
    );

    // ************************************************
    // Internal transfer clock and DMA sequencer
    // ************************************************
    logic eclk_q, div_q, tick, periph, req_act, blocked, strb_end, dma_rd_ev, dma_wr_ev;
    logic [2:0] cnt_q, cnt_d, dly;
    bfp_pkg::bfp_dma_st_t st_q, st_d;

    always_comb begin
        periph = gc_q[bfp_pkg::GC_PERIPH];
        // Divide by two keeps every other external rising edge
        tick = ext_clk && !eclk_q && (div_q || !gc_q[bfp_pkg::GC_CLK_DIV]);
        req_act = dma_req ^ gc_q[bfp_pkg::GC_REQ_POL];
        blocked = dma_dir_read ? flags[0] : flags[6];
        dly = {1'b0, gc_q[bfp_pkg::GC_DLY_HI:bfp_pkg::GC_DLY_LO]} + bfp_pkg::REQ_ACK_BASE;
        strb_end = (st_q == bfp_pkg::BFP_ST_STRB) && tick && (cnt_q[0] == gc_q[bfp_pkg::GC_STRB_LEN]);
        dma_rd_ev = (st_q == bfp_pkg::BFP_ST_ACK) && tick && dma_dir_read;
        dma_wr_ev = strb_end && !dma_dir_read;
        st_d = st_q;
        cnt_d = cnt_q;
        case (st_q)
            bfp_pkg::BFP_ST_IDLE: begin
                if (tick && req_act) begin
                    st_d = bfp_pkg::BFP_ST_WAIT;
                    cnt_d = 3'h1;
                end
            end
            bfp_pkg::BFP_ST_WAIT: begin
                if (tick && !req_act)
                    st_d = bfp_pkg::BFP_ST_IDLE;
                else if (tick && cnt_q >= dly && !blocked)
                    st_d = bfp_pkg::BFP_ST_ACK;
                else if (tick && cnt_q < dly)
                    cnt_d = cnt_q + 3'h1;
            end
            bfp_pkg::BFP_ST_ACK: begin
                if (tick) begin
                    st_d = bfp_pkg::BFP_ST_STRB;
                    cnt_d = 3'h0;
                end
            end
            default: begin
                if (strb_end)
                    st_d = (req_act && !blocked) ? bfp_pkg::BFP_ST_ACK : bfp_pkg::BFP_ST_IDLE;
                else if (tick)
                    cnt_d = cnt_q + 3'h1;
            end
        endcase
        if (!periph || reset_all)
            st_d = bfp_pkg::BFP_ST_IDLE;
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            eclk_q <= 1'b0;
            div_q <= 1'b0;
            st_q <= bfp_pkg::BFP_ST_IDLE;
            cnt_q <= 3'h0;
        end else begin
            eclk_q <= ext_clk;
            div_q <= (ext_clk && !eclk_q) ? !div_q : div_q;
            st_q <= st_d;
            cnt_q <= cnt_d;
        end
    end

    // ************************************************
    // Byte packing, unpacking and parity
    // ************************************************
    logic [8:0] hold_q, hold_d, dout_q, dout_d, in_b, rd_b;
    logic valid_q, valid_d, half_q, half_d, werr_q, werr_d, rerr_q, rerr_d;
    logic [1:0] bcnt_q, bcnt_d;
    logic sep_strb, proc_rd, proc_wr, rd_ev, wr_ev, acc, even, order, exp_on;
    logic rdn_p_q, wrn_p_q, dsn_p_q;

    always_comb begin
        sep_strb = !gc_q[bfp_pkg::GC_STROBE_STYLE];
        even = pc_q[bfp_pkg::PC_EVEN];
        order = gc_q[bfp_pkg::GC_BYTE_ORDER];
        exp_on = gc_q[bfp_pkg::GC_WEXP_HI];
        proc_rd = sep_strb ? (rdn_p_q && !narrow_port_read_strobe_n_i)
                           : (dsn_p_q && !narrow_port_data_strobe_n_i && narrow_port_direction_line_i);
        proc_wr = sep_strb ? (wrn_p_q && !narrow_port_write_strobe_n_i)
                           : (dsn_p_q && !narrow_port_data_strobe_n_i && !narrow_port_direction_line_i);
        // Slave takes the first two bytes of four, master the last two
        acc = !exp_on || (bcnt_q[1] == gc_q[bfp_pkg::GC_WEXP_LO]);
        rd_ev = (periph ? dma_rd_ev : proc_rd) && !reset_all;
        wr_ev = (periph ? dma_wr_ev : proc_wr) && !reset_all;
        in_b = narrow_port_data_bits_i;
        if (pc_q[bfp_pkg::PC_IN_GEN])
            in_b[8] = even ? ^in_b[7:0] : ~^in_b[7:0];
        rd_b = (half_q ^ order) ? {fwd_rdata[17], fwd_rdata[15:8]} : {fwd_rdata[16], fwd_rdata[7:0]};
        if (pc_q[bfp_pkg::PC_OUT_GEN])
            rd_b[8] = even ? ^rd_b[7:0] : ~^rd_b[7:0];
        rev_word = order ? {hold_q[8], in_b[8], hold_q[7:0], in_b[7:0]}
                         : {in_b[8], hold_q[8], in_b[7:0], hold_q[7:0]};
        rev_push = wr_ev && acc && valid_q;
        fwd_pop = rd_ev && acc && half_q;
        hold_d = hold_q;
        valid_d = valid_q;
        half_d = half_q;
        dout_d = dout_q;
        werr_d = werr_q;
        rerr_d = rerr_q;
        // Clear first, so an error caught in the same cycle still sticks
        if (reset_all || (cfg_wr && (cfg_idx == bfp_pkg::CFG_PARITY))) begin
            werr_d = 1'b0;
            rerr_d = 1'b0;
        end
        bcnt_d = (rd_ev || wr_ev) && exp_on ? bcnt_q + 2'h1 : bcnt_q;
        if (wr_ev && acc) begin
            valid_d = !valid_q;
            if (!valid_q)
                hold_d = in_b;
            if (!pc_q[bfp_pkg::PC_IN_GEN] && (in_b[8] != (even ? ^in_b[7:0] : ~^in_b[7:0])))
                werr_d = 1'b1;
        end
        if (rd_ev && acc) begin
            half_d = !half_q;
            dout_d = rd_b;
            if (!pc_q[bfp_pkg::PC_OUT_GEN] && (rd_b[8] != (even ? ^rd_b[7:0] : ~^rd_b[7:0])))
                rerr_d = 1'b1;
        end
        if (reset_all) begin
            valid_d = 1'b0;
            half_d = 1'b0;
            bcnt_d = 2'h0;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            hold_q <= 9'h000;
            dout_q <= 9'h000;
            valid_q <= 1'b0;
            half_q <= 1'b0;
            werr_q <= 1'b0;
            rerr_q <= 1'b0;
            bcnt_q <= 2'h0;
            rdn_p_q <= 1'b1;
            wrn_p_q <= 1'b1;
            dsn_p_q <= 1'b1;
        end else begin
            hold_q <= hold_d;
            dout_q <= dout_d;
            valid_q <= valid_d;
            half_q <= half_d;
            werr_q <= werr_d;
            rerr_q <= rerr_d;
            bcnt_q <= bcnt_d;
            rdn_p_q <= narrow_port_read_strobe_n_i;
            wrn_p_q <= narrow_port_write_strobe_n_i;
            dsn_p_q <= narrow_port_data_strobe_n_i;
        end
    end

    // ************************************************
    // Registered pins and status
    // ************************************************
    logic [3:0] pin_d;
    logic [15:0] stat_d;
    logic ack_on, strb_on, ack_d, rdn_d, wrn_d, dsn_d, dir_d, doe_d;

    for (genvar p = 0; p < 4; p++) begin : g_pin
        assign pin_d[p] = (p == 0 && pc_q[bfp_pkg::PC_ERR_FLAG_PIN_A]) ? (werr_q || rerr_q)
                                                                  : flags[fr_q[4*p +: 3]];
    end

    always_comb begin
        ack_on = periph && (st_q == bfp_pkg::BFP_ST_ACK || st_q == bfp_pkg::BFP_ST_STRB);
        strb_on = periph && st_q == bfp_pkg::BFP_ST_STRB;
        ack_d = ack_on ? gc_q[bfp_pkg::GC_ACK_POL] : !gc_q[bfp_pkg::GC_ACK_POL];
        rdn_d = !(strb_on && sep_strb && dma_dir_read);
        wrn_d = !(strb_on && sep_strb && !dma_dir_read);
        dsn_d = !(strb_on && !sep_strb);
        dir_d = ack_on ? dma_dir_read : 1'b1;
        doe_d = !(periph ? (strb_on && dma_dir_read)
                         : (sep_strb ? !narrow_port_read_strobe_n_i
                                     : (!narrow_port_data_strobe_n_i && narrow_port_direction_line_i)));
        stat_d = 16'h0000;
        stat_d[bfp_pkg::ST_VALID] = valid_q;
        stat_d[bfp_pkg::ST_WERR] = werr_q;
        stat_d[bfp_pkg::ST_RERR] = rerr_q;
        stat_d[bfp_pkg::ST_FMT] = status_format;
        stat_d[15:12] = {flags[5], flags[4], flags[3], flags[2]};
        if (status_format)
            stat_d[7:3] = {flags[7], flags[6], flags[1], flags[0], dma_dir_read};
        else
            stat_d[7:0] = hold_q[7:0];
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            external_flag_pins <= 4'h1;
            status_word <= 16'h0000;
            rev_rdata <= 18'h00000;
            dma_ack <= 1'b1;
            narrow_port_read_strobe_n_o <= 1'b1;
            narrow_port_write_strobe_n_o <= 1'b1;
            narrow_port_data_strobe_n_o <= 1'b1;
            narrow_port_direction_line_o <= 1'b1;
            narrow_port_ctrl_oe_n <= 1'b1;
            narrow_port_data_bits_o <= 9'h000;
            narrow_port_data_oe_n <= 1'b1;
        end else begin
            external_flag_pins <= pin_d;
            status_word <= stat_d;
            rev_rdata <= rev_rdata_w;
            dma_ack <= ack_d;
            narrow_port_read_strobe_n_o <= rdn_d;
            narrow_port_write_strobe_n_o <= wrn_d;
            narrow_port_data_strobe_n_o <= dsn_d;
            narrow_port_direction_line_o <= dir_d;
            narrow_port_ctrl_oe_n <= !periph;
            narrow_port_data_bits_o <= dout_q;
            narrow_port_data_oe_n <= doe_d;
        end
    end

    // ************************************************
    // Checks
    // ************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    sequence s_wait_done;
        st_q == bfp_pkg::BFP_ST_WAIT && tick && cnt_q >= dly && !blocked && req_act && periph && !reset_all;
    endsequence

    AST_PERR_PIN_A: assert property (pc_q[bfp_pkg::PC_ERR_FLAG_PIN_A] && (werr_q || rerr_q) |=> external_flag_pins[0])
        else $error("parity error not on flag pin A");
    AST_FLAG_ROUTE: assert property (!pc_q[bfp_pkg::PC_ERR_FLAG_PIN_A] |=> external_flag_pins[0] == $past(flags[fr_q[2:0]]))
        else $error("flag pin A not routed by code");
    AST_OFFSET_CLEAR: assert property (reset_all |=> off_q[0] == '0 && off_q[3] == '0 && gc_q == '0)
        else $error("reset all did not clear offsets");
    AST_FIRST_WRITE: assert property (wr_ev && acc && !valid_q |=> valid_q && hold_q == $past(in_b))
        else $error("first write not held");
    AST_SECOND_WRITE: assert property (wr_ev && acc && valid_q |-> rev_push ##1 !valid_q)
        else $error("second write did not push");
    AST_HALF_POP: assert property (rd_ev && acc && !half_q |-> !fwd_pop ##1 half_q)
        else $error("pop on first half");
    AST_ACK_START: assert property (s_wait_done |=> st_q == bfp_pkg::BFP_ST_ACK ##1 dma_ack == gc_q[bfp_pkg::GC_ACK_POL])
        else $error("acknowledge not raised after delay");
    AST_ACK_BLOCK: assert property (st_q == bfp_pkg::BFP_ST_WAIT && blocked |=> st_q != bfp_pkg::BFP_ST_ACK)
        else $error("acknowledge given while blocked");
    AST_PROC_IDLE: assert property (!periph |=> dma_ack == !$past(gc_q[bfp_pkg::GC_ACK_POL]) && narrow_port_ctrl_oe_n)
        else $error("DMA active in processor mode");
endmodule // bfp_port_b
`default_nettype wire

// [inc/bfp_pkg.sv]
// Constants and types shared by the narrow-port and flag logic
package bfp_pkg;
    // ************************************************
    // Array geometry, counted in 18-bit words
    // ************************************************
    localparam int DEPTH = 512;
    localparam int AW = 9;
    localparam int PW = 10;
    localparam int OFFW = 10;
    localparam logic [PW-1:0] DEPTH_P = 10'h200;

    // ************************************************
    // Configuration register indices
    // ************************************************
    localparam logic [2:0] CFG_AE_FWD = 3'h0;
    localparam logic [2:0] CFG_AF_FWD = 3'h1;
    localparam logic [2:0] CFG_AE_REV = 3'h2;
    localparam logic [2:0] CFG_AF_REV = 3'h3;
    localparam logic [2:0] CFG_FLAG_ROUTE = 3'h4;
    localparam logic [2:0] CFG_GEN_CTRL = 3'h5;
    localparam logic [2:0] CFG_PARITY = 3'h7;

    // ************************************************
    // General control fields
    // ************************************************
    localparam int GC_STROBE_STYLE = 0;
    localparam int GC_BYTE_ORDER = 1;
    localparam int GC_FULL_DEF = 2;
    localparam int GC_EMPTY_DEF = 3;
    localparam int GC_REQ_POL = 4;
    localparam int GC_ACK_POL = 5;
    localparam int GC_DLY_LO = 6;
    localparam int GC_DLY_HI = 7;
    localparam int GC_STRB_LEN = 8;
    localparam int GC_CLK_DIV = 9;
    localparam int GC_PERIPH = 10;
    localparam int GC_WEXP_LO = 11;
    localparam int GC_WEXP_HI = 12;
    localparam logic [1:0] WEXP_SLAVE = 2'h2;
    localparam logic [1:0] WEXP_MASTER = 2'h3;
    localparam logic [2:0] REQ_ACK_BASE = 3'h2;

    // ************************************************
    // Parity control fields
    // ************************************************
    localparam int PC_IN_GEN = 8;
    localparam int PC_OUT_GEN = 9;
    localparam int PC_EVEN = 10;
    localparam int PC_ERR_FLAG_PIN_A = 11;

    // ************************************************
    // Status bit positions and reset values
    // ************************************************
    localparam int ST_VALID = 8;
    localparam int ST_WERR = 9;
    localparam int ST_RERR = 10;
    localparam int ST_FMT = 11;
    localparam int ST_DMA_DIR = 3;
    localparam logic [15:0] GC_RST = 16'h0000;
    localparam logic [15:0] PC_RST = 16'h0000;
    localparam logic [15:0] FR_RST = 16'h0000;
    localparam logic [OFFW-1:0] OFF_RST = 10'h000;

    typedef enum logic [1:0] {BFP_ST_IDLE, BFP_ST_WAIT, BFP_ST_ACK, BFP_ST_STRB} bfp_dma_st_t;
endpackage

// [tb/bfp_nhost.sv]
// Processor model driving the narrow port strobes and data
`timescale 1ns/1ps
`default_nettype none
module bfp_nhost (
    input wire logic mclk,
    input wire logic [8:0] bus,
    output logic wr_n,
    output logic rd_n,
    output logic [8:0] dq
);
    initial begin
        wr_n = 1'b1;
        rd_n = 1'b1;
        dq = 9'h0ff;
    end
    task automatic put(input logic [8:0] b);
        dq <= b;
        wr_n <= 1'b0;
        repeat (3) @(posedge mclk);
        wr_n <= 1'b1;
        // Released line shows the inverse, never a stale copy
        dq <= ~b;
        repeat (3) @(posedge mclk);
    endtask
    task automatic get(output logic [8:0] b);
        rd_n <= 1'b0;
        repeat (4) @(posedge mclk);
        b = bus;
        rd_n <= 1'b1;
        repeat (2) @(posedge mclk);
    endtask
endmodule // bfp_nhost
`default_nettype wire

// [tb/bfp_port_b_tb_top.sv]
// Self-checking bench for narrow-port packing, parity and flag routing
`timescale 1ns/1ps
`default_nettype none
module bfp_port_b_tb_top;
    logic mclk = 1'b0, nrst = 1'b0, rst_all = 1'b0, cw = 1'b0, fmt = 1'b0, psh = 1'b0, z = 1'b0, one = 1'b1;
    logic [2:0] idx = 3'h0;
    logic [15:0] wd = 16'h0000, st;
    logic [17:0] fw = 18'h00000, rr;
    logic [8:0] bus, hq, dqo, rb;
    logic wr_n, rd_n, doe, coe;
    logic ext = 1'b0, req = 1'b0, dir = 1'b0, ack, wso, rso;
    logic [3:0] pins;
    int errors = 0, n_compared = 0, cyc = 0;
    always #5 mclk = ~mclk;
    assign bus = doe ? hq : dqo;
    bfp_nhost host (.mclk(mclk), .bus(bus), .wr_n(wr_n), .rd_n(rd_n), .dq(hq));
    bfp_port_b dut (.mclk(mclk), .nrst(nrst), .reset_all(rst_all), .cfg_wr(cw), .cfg_idx(idx), .cfg_wdata(wd),
        .status_format(fmt), .status_word(st), .fwd_push(psh), .fwd_wdata(fw), .rev_pop(z), .rev_rdata(rr),
        .ld_reread(z), .reread(z), .ld_rewrite(z), .rewrite(z), .ext_clk(ext), .dma_req(req), .dma_dir_read(dir),
        .dma_ack(ack), .narrow_port_read_strobe_n_i(rd_n), .narrow_port_read_strobe_n_o(rso),
        .narrow_port_write_strobe_n_i(wr_n), .narrow_port_write_strobe_n_o(wso),
        .narrow_port_data_strobe_n_i(one), .narrow_port_data_strobe_n_o(), .narrow_port_direction_line_i(one),
        .narrow_port_direction_line_o(), .narrow_port_ctrl_oe_n(coe), .narrow_port_data_bits_i(bus),
        .narrow_port_data_bits_o(dqo), .narrow_port_data_oe_n(doe), .external_flag_pins(pins));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cfg(input logic [2:0] i, input logic [15:0] d);
        cw <= 1'b1;
        idx <= i;
        wd <= d;
        @(posedge mclk);
        cw <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask
    task automatic wrap_up;
        if (errors == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 2000) begin
            errors++;
            wrap_up();
        end
    end
    task automatic t_route;
        cfg(bfp_pkg::CFG_FLAG_ROUTE, 16'h7a04);
        chk(pins, 4'h3);
        cfg(bfp_pkg::CFG_GEN_CTRL, 16'h0400);
        chk(coe, 1'b0);
        cfg(bfp_pkg::CFG_GEN_CTRL, 16'h0000);
    endtask
    task automatic t_pack;
        host.put(9'h1a5);
        chk(st[8:0], 9'h1a5);
        host.put(9'h13c);
        chk(st[8], 1'b0);
        chk(pins, 4'h2);
        chk(rr, 18'h33ca5);
    endtask
    task automatic t_unpack;
        psh <= 1'b1;
        fw <= 18'h15a3c;
        @(posedge mclk);
        psh <= 1'b0;
        fmt <= 1'b1;
        repeat (3) @(posedge mclk);
        host.get(rb);
        chk(rb, 9'h13c);
        chk(st[11:4], 8'h80);
        host.get(rb);
        chk(rb, 9'h05a);
        chk(st[10], 1'b1);
        chk(st[4], 1'b1);
        fmt <= 1'b0;
    endtask
    task automatic t_perr;
        host.put(9'h000);
        chk(st[9], 1'b1);
        cfg(bfp_pkg::CFG_PARITY, 16'h0800);
        host.put(9'h101);
        chk(pins[0], 1'b1);
        cfg(bfp_pkg::CFG_PARITY, 16'h0c00);
        host.put(9'h000);
        chk({st[9], pins[0]}, 2'h0);
        rst_all <= 1'b1;
        @(posedge mclk);
        rst_all <= 1'b0;
        repeat (3) @(posedge mclk);
        chk({coe, pins, st}, 21'h1fc000);
    endtask
    task automatic t_dma(input logic d, input logic [2:0] exp, input logic [31:0] at);
        logic [2:0] seen;
        logic [31:0] first;
        seen = 3'h0;
        first = 32'hffffffff;
        // Separate strobes, two-clock delay, one-clock strobe, undivided
        cfg(bfp_pkg::CFG_GEN_CTRL, 16'h0400);
        dir <= d;
        req <= 1'b1;
        for (int k = 0; k < 24; k++) begin
            @(negedge mclk);
            if (!ack && first == 32'hffffffff)
                first = k;
            seen = seen | {!ack, !wso, !rso};
            @(posedge mclk);
            ext <= ~ext;
        end
        req <= 1'b0;
        chk(seen, exp);
        chk(first, at);
        cfg(bfp_pkg::CFG_GEN_CTRL, 16'h0000);
    endtask
    initial begin
        repeat (12) @(posedge mclk);
        chk(pins, 4'h1);
        nrst <= 1'b1;
        repeat (3) @(posedge mclk);
        chk({coe, pins, st}, 21'h1fc000);
        t_route();
        t_pack();
        t_unpack();
        t_perr();
        t_dma(1'b0, 3'h6, 32'h00000007);
        t_dma(1'b1, 3'h0, 32'hffffffff);
        wrap_up();
    end
endmodule // bfp_port_b_tb_top
`default_nettype wire
